//--- spsb_codec.sv
// Far-side serial device: clock and sync per frame, feeds and captures both lines
`timescale 1ns/100ps
module spsb_codec (
	output reg sclk, // Serial clock, still between frames
	output reg fs, // Frame sync
	output reg da, // A data to the port
	output reg db, // B data to the port
	input wire qa, // A data from the port
	input wire qb // B data from the port
);
	reg [31:0] ra;
	reg [31:0] rb;
	initial begin
		sclk = 1'b0;
		fs = 1'b0;
		da = 1'b0;
		db = 1'b0;
	end
	// One frame of n bits, MSB first, both lines on the same edges
	task frame(input [31:0] wa, input [31:0] wb, input integer n);
		integer i;
		begin
			ra = 32'h0000_0000;
			rb = 32'h0000_0000;
			#3 fs = 1'b1;
			#40 sclk = 1'b1;
			for (i = n - 1; i >= 0; i = i - 1) begin
				#40 sclk = 1'b0;
				fs = 1'b0;
				da = wa[i];
				db = wb[i];
				#40 sclk = 1'b1;
				ra[i] = qa;
				rb[i] = qb;
			end
			#40 sclk = 1'b0;
			// Stale bits flip so a late sample never passes as data
			da = ~da;
			db = ~db;
			#40;
		end
	endtask
endmodule // spsb_codec

//--- spsb_map.vh
// Register map, field positions and constants of the serial port buffer block
// Function
// - Receive direction: transmit buffers and shifters ignore clock and sync; full writes hang.
// - Receive path per channel is a three-deep queue: two holders plus shifter.
// - Channel A status in bits 31-30, B in 28-27; 00 empty, 10 partial, 11 full.
// - Core read of empty receive or write of full transmit waits for serial service.
// - Buffer status keeps following core reads and writes while the port is disabled.
// - Transmit, sync required: error set when a frame sync finds the buffer empty.
// - Transmit, sync not required: error set whenever a due word finds the buffer empty.
// - A transmitting port starts a word on every frame sync detected between words; a sync during a word is ignored.
// - Receive: error marks overflow; a new word while full replaces stored data.
// - With two unread words, a third replaces the second held word.
// - Overflow is raised on the final bit of the third word.
// - Error flags are sticky and cleared only by disabling their channel.
// - Receive direction: core writes fill transmit status to full, then hang forever.
// - Data-independent sync option makes frame syncs regardless of buffer state, non-multichannel.
// - Multichannel odd port: error bit is receive overflow on new data while full.
// - Multichannel even port: error bit is transmit underflow on sync with buffer empty.
// - Standard, left-justified and I2S: both channels shift in lockstep on same edges.
// - Control bit 11 picks I2S/left-justified family; bit 17 picks I2S or left-justified.
// - Multichannel: control bit 0 enables A channels, bit 23 enables B channels.
// - Word lengths 3-32 in standard and multichannel, 8-32 in I2S and left-justified.
// - Words under 32 bits sit right-aligned in transmit and receive buffers.
// - Port pairs are coupled only for multichannel operation and loopback test.
// - Transmit direction: receive buffers ignore clock and sync; status stays empty.
// - Transmit path: data register plus shifter; data moves when previous word went out.
`ifndef SPSB_MAP_VH
`define SPSB_MAP_VH
`define SPSB_OFF_CTRL 4'h0
`define SPSB_OFF_MCTL 4'h4
`define SPSB_OFF_TXA 4'h8
`define SPSB_OFF_TXB 4'hC
`define SPSB_OFF_RXA 4'h0
`define SPSB_OFF_RXA_HI 4'h1
`define SPSB_CTRL_RST 32'h0000_0000
`define SPSB_MCTL_RST 32'h0000_0000
`define SPSB_B_EN_A 0
`define SPSB_B_WORD_LENGTH_FIELD_LO 4
`define SPSB_B_WORD_LENGTH_FIELD_HI 8
`define SPSB_B_FAMILY 11
`define SPSB_B_FSR 13
`define SPSB_B_IFS 14
`define SPSB_B_DATA_INDEPENDENT_SYNC 15
`define SPSB_B_LAFS 17
`define SPSB_B_EN_B 24
`define SPSB_B_DIR 25
`define SPSB_B_ERR_B 26
`define SPSB_B_STAT_B_LO 27
`define SPSB_B_ERR_A 29
`define SPSB_B_STAT_A_LO 30
`define SPSB_B_MC_A 0
`define SPSB_B_MC_B 23
`define SPSB_WORD_LENGTH_FIELD_MIN_STD 5'h02
`define SPSB_WORD_LENGTH_FIELD_MIN_I2S 5'h07
`define SPSB_ST_EMPTY 2'h0
`define SPSB_ST_PART 2'h2
`define SPSB_ST_FULL 2'h3
`endif

//--- spsb_top.v
// Buffer, status and mode logic of a two-channel synchronous serial port
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`include "spsb_map.vh"
module spsb_top #(
	parameter PORT_ODD = 1'b0 // Multichannel direction: 1 = receive port
) (
	input wire SYS_CLK, // 125 MHz system clock
	input wire RST_N, // Synchronous reset, active low
	input wire [4:0] REG_ADDR, // Register byte address
	input wire [31:0] REG_WDATA, // Write data
	input wire REG_WR, // Write strobe
	input wire REG_RD, // Read strobe
	output reg [31:0] REG_RDATA, // Read data
	output reg REG_RVALID, // Read data valid pulse
	output wire REG_HOLD, // Core access held off
	input wire SCLK_IN, // Serial clock line
	input wire FS_IN, // Frame sync line input
	output wire FS_OUT, // Frame sync line output
	output wire FS_OE, // Frame sync drive enable
	input wire DA_IN, // Channel A data input
	input wire DB_IN, // Channel B data input
	output reg DA_OUT, // Channel A data output
	output reg DB_OUT, // Channel B data output
	output wire DA_OE, // Channel A drive enable
	output wire DB_OE // Channel B drive enable
);

	// Status field coding from occupancy count
	function [1:0] stat_code;
		input [1:0] cnt;
		begin
			case (cnt)
				2'h0: stat_code = `SPSB_ST_EMPTY;
				2'h1: stat_code = `SPSB_ST_PART;
				default: stat_code = `SPSB_ST_FULL;
			endcase
		end
	endfunction

	// Transmit occupancy from the two valid bits, same scale as receive
	function [1:0] tx_level;
		input dv;
		input sv;
		begin
			tx_level = {dv & sv, dv ^ sv};
		end
	endfunction

	// Software-visible configuration
	reg [31:0] ctrl_r;
	reg [31:0] mctl_r;

	// Transmit queue per channel: data register and shifter
	reg [31:0] txd_r [0:1];
	reg [31:0] txs_r [0:1];

	// Receive queue per channel: two holders and shifter
	reg [31:0] rxh0_r [0:1];
	reg [31:0] rxh1_r [0:1];
	reg [31:0] rxsh_r [0:1];
	reg [1:0] rxcnt_r [0:1];

	// Queue flags and sticky errors
	reg [1:0] txdv_r;
	reg [1:0] txsv_r;
	reg [1:0] send_r;
	reg [1:0] err_r;

	// Serial side synchronisers
	reg [2:0] sclk_q;
	reg [1:0] fs_q;
	reg [1:0] da_q;
	reg [1:0] db_q;

	// Word engine and held access
	reg active_r;
	reg running_r;
	reg fs_int_r;
	reg [5:0] rem_r;
	reg pend_r;
	reg pend_wr_r;
	reg pend_ch_r;
	reg [31:0] pend_data_r;
	integer i;

	// Mode decode
	wire family = ctrl_r[`SPSB_B_FAMILY];
	wire lafs = ctrl_r[`SPSB_B_LAFS];
	wire mc_on = ~family & (mctl_r[`SPSB_B_MC_A] | mctl_r[`SPSB_B_MC_B]);
	wire [1:0] en;
	assign en[0] = mc_on ? mctl_r[`SPSB_B_MC_A] : ctrl_r[`SPSB_B_EN_A];
	assign en[1] = mc_on ? mctl_r[`SPSB_B_MC_B] : ctrl_r[`SPSB_B_EN_B];
	// Pairing only fixes direction in multichannel; otherwise the control bit rules
	wire tx_dir = mc_on ? ~PORT_ODD : ctrl_r[`SPSB_B_DIR];
	wire port_on = en[0] | en[1];
	wire frame_sync_required = ctrl_r[`SPSB_B_FSR];
	wire ifs = ctrl_r[`SPSB_B_IFS];
	wire data_independent_sync = ctrl_r[`SPSB_B_DATA_INDEPENDENT_SYNC] & ~mc_on;
	wire [4:0] word_length_field_raw = ctrl_r[`SPSB_B_WORD_LENGTH_FIELD_HI:`SPSB_B_WORD_LENGTH_FIELD_LO];
	// Out-of-range lengths are clamped so a bad field cannot lock the counter
	wire [4:0] word_length_field_min = family ? `SPSB_WORD_LENGTH_FIELD_MIN_I2S : `SPSB_WORD_LENGTH_FIELD_MIN_STD;
	wire [4:0] word_length_field = (word_length_field_raw < word_length_field_min) ? word_length_field_min : word_length_field_raw;
	wire [5:0] word_bits = {1'b0, word_length_field} + 6'h01;

	// Status fields follow the direction: transmit queue or receive queue
	wire [1:0] stat_a = stat_code(tx_dir ? tx_level(txdv_r[0], txsv_r[0]) : rxcnt_r[0]);
	wire [1:0] stat_b = stat_code(tx_dir ? tx_level(txdv_r[1], txsv_r[1]) : rxcnt_r[1]);
	wire [31:0] status_word = {stat_a, err_r[0], stat_b, err_r[1], ctrl_r[25:0]};
	// Sync demand: data waiting to send, or room left to receive
	wire fs_want = data_independent_sync | (tx_dir ? |(txsv_r & en) : ((rxcnt_r[0] != 2'h2) | (rxcnt_r[1] != 2'h2)));

	// Link edge detection after two-flop synchronisers
	wire sclk_rise = sclk_q[1] & ~sclk_q[2];
	wire sclk_fall = ~sclk_q[1] & sclk_q[2];
	wire fs_seen = ifs ? fs_int_r : fs_q[1];
	wire start = sclk_rise & port_on & ~active_r & (fs_seen | (~frame_sync_required & running_r));
	wire [1:0] din = {db_q[1], da_q[1]};
	wire rx_last = sclk_rise & active_r & ~tx_dir & (rem_r == 6'h01);
	wire tx_last = sclk_fall & active_r & tx_dir & (rem_r == 6'h01);

	// Core access decode; a held access retries every cycle
	wire acc_wr = pend_r ? pend_wr_r : REG_WR;
	wire acc_rd = pend_r ? ~pend_wr_r : REG_RD;
	wire acc_any = pend_r | REG_WR | REG_RD;
	wire [4:0] acc_addr = REG_ADDR;
	wire acc_ch = pend_r ? pend_ch_r : acc_addr[2];
	wire is_tx = ~pend_r & (acc_addr[4:3] == 2'h1);
	wire is_rx = ~pend_r & (acc_addr[4:3] == 2'h2);
	wire [31:0] acc_data = pend_r ? pend_data_r : REG_WDATA;
	wire tx_full_sel = txdv_r[acc_ch] & txsv_r[acc_ch];
	wire rx_empty_sel = (rxcnt_r[acc_ch] == 2'h0);
	wire tx_wr_req = acc_wr & (pend_r ? 1'b1 : is_tx);
	wire rx_rd_req = acc_rd & (pend_r ? 1'b1 : is_rx);
	wire tx_push = tx_wr_req & ~tx_full_sel;
	wire rx_pop = rx_rd_req & ~rx_empty_sel;
	wire hold_new = (tx_wr_req & tx_full_sel) | (rx_rd_req & rx_empty_sel);
	wire rx_core_push = ~pend_r & REG_WR & is_rx;
	assign REG_HOLD = pend_r;

	// Pins: syncs only when generated here, data only in transmit
	assign FS_OUT = fs_int_r;
	assign FS_OE = ifs & port_on;
	assign DA_OE = tx_dir & en[0];
	assign DB_OE = tx_dir & en[1];

	// Input synchronisers for clock, sync and data lines
	always @(posedge SYS_CLK) begin
		if (!RST_N) begin
			sclk_q <= 3'h0;
			fs_q <= 2'h0;
			da_q <= 2'h0;
			db_q <= 2'h0;
		end else begin
			sclk_q <= {sclk_q[1:0], SCLK_IN};
			fs_q <= {fs_q[0], FS_IN};
			da_q <= {da_q[0], DA_IN};
			db_q <= {db_q[0], DB_IN};
		end
	end

	// Control registers; software may write any bit but the status fields
	always @(posedge SYS_CLK) begin
		if (!RST_N) begin
			ctrl_r <= `SPSB_CTRL_RST;
			mctl_r <= `SPSB_MCTL_RST;
		end else if (REG_WR & ~pend_r) begin
			if (REG_ADDR == {1'b0, `SPSB_OFF_CTRL})
				ctrl_r <= {6'h00, REG_WDATA[25:0]};
			if (REG_ADDR == {1'b0, `SPSB_OFF_MCTL})
				mctl_r <= REG_WDATA;
		end
	end

	// Held-off access bookkeeping
	always @(posedge SYS_CLK) begin
		if (!RST_N) begin
			pend_r <= 1'b0;
			pend_wr_r <= 1'b0;
			pend_ch_r <= 1'b0;
			pend_data_r <= 32'h0000_0000;
		end else if (pend_r) begin
			if (tx_push | rx_pop)
				pend_r <= 1'b0;
		end else if (hold_new) begin
			pend_r <= 1'b1;
			pend_wr_r <= REG_WR;
			pend_ch_r <= REG_ADDR[2];
			pend_data_r <= REG_WDATA;
		end
	end

	// Read data one cycle after the strobe, or when a held read completes
	always @(posedge SYS_CLK) begin
		if (!RST_N) begin
			REG_RDATA <= 32'h0000_0000;
			REG_RVALID <= 1'b0;
		end else begin
			REG_RVALID <= (REG_RD & ~pend_r & ~hold_new) | (pend_r & rx_pop);
			if (rx_pop)
				REG_RDATA <= rxh0_r[acc_ch];
			else if (REG_RD & ~pend_r) begin
				case (REG_ADDR)
					{1'b0, `SPSB_OFF_CTRL}: REG_RDATA <= status_word;
					{1'b0, `SPSB_OFF_MCTL}: REG_RDATA <= mctl_r;
					{1'b0, `SPSB_OFF_TXA}: REG_RDATA <= txd_r[0];
					{1'b0, `SPSB_OFF_TXB}: REG_RDATA <= txd_r[1];
					default: REG_RDATA <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Shared bit counter keeps both channels on the same serial edges
	always @(posedge SYS_CLK) begin
		if (!RST_N) begin
			active_r <= 1'b0;
			running_r <= 1'b0;
			rem_r <= 6'h00;
		end else if (!port_on) begin
			active_r <= 1'b0;
			running_r <= 1'b0;
			rem_r <= 6'h00;
		end else if (start) begin
			active_r <= 1'b1;
			running_r <= 1'b1;
			rem_r <= word_bits;
		end else if ((sclk_rise & ~tx_dir) | (sclk_fall & tx_dir)) begin
			if (active_r) begin
				rem_r <= rem_r - 6'h01;
				if (rem_r == 6'h01)
					active_r <= 1'b0;
			end
		end
	end

	// Internal frame sync, one serial period wide, launched on a falling edge
	// Without the data-independent option it waits for buffer room or data
	always @(posedge SYS_CLK) begin
		if (!RST_N) begin
			fs_int_r <= 1'b0;
		end else if (!ifs | !port_on) begin
			fs_int_r <= 1'b0;
		end else if (sclk_fall) begin
			fs_int_r <= ~fs_int_r & ~active_r & fs_want;
		end
	end

	// Transmit data pins change on falling edges only
	always @(posedge SYS_CLK) begin
		if (!RST_N) begin
			DA_OUT <= 1'b0;
			DB_OUT <= 1'b0;
		end else if (sclk_fall & active_r & tx_dir) begin
			DA_OUT <= send_r[0] & txs_r[0][rem_r[4:0] - 5'h01];
			DB_OUT <= send_r[1] & txs_r[1][rem_r[4:0] - 5'h01];
		end
	end

	// Per-channel buffers, queues and sticky error flags
	always @(posedge SYS_CLK) begin
		if (!RST_N) begin
			txdv_r <= 2'h0;
			txsv_r <= 2'h0;
			send_r <= 2'h0;
			err_r <= 2'h0;
			for (i = 0; i < 2; i = i + 1) begin
				txd_r[i] <= 32'h0000_0000;
				txs_r[i] <= 32'h0000_0000;
				rxh0_r[i] <= 32'h0000_0000;
				rxh1_r[i] <= 32'h0000_0000;
				rxsh_r[i] <= 32'h0000_0000;
				rxcnt_r[i] <= 2'h0;
			end
		end else begin
			for (i = 0; i < 2; i = i + 1) begin
				// Errors clear only while the channel is off; sets need it on
				if (!en[i])
					err_r[i] <= 1'b0;
				// Move before load: a write landing with a move must not overwrite the waiting word
				if (txdv_r[i] & ~txsv_r[i]) begin
					txs_r[i] <= txd_r[i];
					txsv_r[i] <= 1'b1;
					txdv_r[i] <= 1'b0;
				end
				// Core writes fill the queue in either direction; only shifting drains it
				if (tx_push & (acc_ch == i)) begin
					txd_r[i] <= acc_data;
					txdv_r[i] <= 1'b1;
				end
				// Transmit word start: missing data is an underflow
				if (start & tx_dir & en[i]) begin
					send_r[i] <= txsv_r[i];
					if (!txsv_r[i])
						err_r[i] <= 1'b1;
				end
				// Shifter frees on the same falling edge that drives its last bit onto the pin
				if (tx_last & send_r[i]) begin
					txsv_r[i] <= 1'b0;
					send_r[i] <= 1'b0;
				end
				// Receive shifter starts clean so short words land right-aligned
				if (start & ~tx_dir)
					rxsh_r[i] <= 32'h0000_0000;
				else if (sclk_rise & active_r & ~tx_dir & en[i])
					rxsh_r[i] <= {rxsh_r[i][30:0], din[i]};
				queue_step(i);
			end
		end
	end

	// Receive queue: two holders behind the shifter, oldest in holder zero
	task queue_step;
		input integer ch;
		reg push;
		reg pop;
		reg [31:0] nw;
		begin
			push = (rx_last & en[ch]) | (rx_core_push & (REG_ADDR[2] == ch));
			pop = rx_pop & (acc_ch == ch);
			nw = rx_last ? {rxsh_r[ch][30:0], din[ch]} : REG_WDATA;
			if (push & pop) begin
				if (rxcnt_r[ch] == 2'h2) begin
					rxh0_r[ch] <= rxh1_r[ch];
					rxh1_r[ch] <= nw;
				end else begin
					rxh0_r[ch] <= nw;
				end
			end else if (pop) begin
				rxh0_r[ch] <= rxh1_r[ch];
				rxcnt_r[ch] <= rxcnt_r[ch] - 2'h1;
			end else if (push) begin
				if (rxcnt_r[ch] == 2'h0)
					rxh0_r[ch] <= nw;
				else
					rxh1_r[ch] <= nw;
				if (rxcnt_r[ch] != 2'h2)
					rxcnt_r[ch] <= rxcnt_r[ch] + 2'h1;
				else if (rx_last & en[ch])
					err_r[ch] <= 1'b1;
			end
		end
	endtask

	// Left-justified versus I2S only moves sync timing, handled outside this block
	wire unused_ok = lafs;

endmodule // spsb_top

//--- spsb_top_asserts.sv
// Port-level checker of the serial port buffer block
`timescale 1ns/100ps
module spsb_top_asserts (
	input wire SYS_CLK, // Clock
	input wire RST_N, // Reset, active low
	input wire [4:0] REG_ADDR, // Address
	input wire [31:0] REG_WDATA, // Write data
	input wire REG_WR, // Write strobe
	input wire REG_RD, // Read strobe
	input wire [31:0] REG_RDATA, // Read data
	input wire REG_RVALID, // Read valid
	input wire REG_HOLD, // Stall
	input wire FS_OE, // Sync drive
	input wire DA_OE, // A drive
	input wire DA_OUT // A data out
);
	reg [31:0] ctl_r;
	reg crd_r;
	reg hrd_r;
	wire take = !REG_HOLD && REG_ADDR == 5'h00;
	// Control shadow; strobes under stall are dropped, as in the block
	always @(posedge SYS_CLK) begin
		if (!RST_N) begin
			ctl_r <= 32'h0000_0000;
			crd_r <= 1'b0;
			hrd_r <= 1'b0;
		end else begin
			if (REG_WR && take) ctl_r <= REG_WDATA;
			crd_r <= REG_RD && take;
			if (!REG_HOLD && (REG_RD || REG_WR)) hrd_r <= REG_RD;
		end
	end
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	a_ctrl_answer: assert property (REG_RD && take |=> REG_RVALID && !REG_HOLD)
		else $error("control read unanswered");
	a_hold_silent: assert property (REG_HOLD |-> !REG_RVALID)
		else $error("read data during stall");
	a_hold_release: assert property ($fell(REG_HOLD) && hrd_r |-> REG_RVALID)
		else $error("held read ended without data");
	a_status_a_code: assert property (crd_r && REG_RVALID |-> REG_RDATA[31:30] != 2'h1)
		else $error("reserved status on A");
	a_status_b_code: assert property (crd_r && REG_RVALID |-> REG_RDATA[28:27] != 2'h1)
		else $error("reserved status on B");
	a_drive_a: assert property (DA_OE == (ctl_r[25] && ctl_r[0]))
		else $error("A drive enable wrong");
	a_sync_drive: assert property (FS_OE == (ctl_r[14] && (ctl_r[0] || ctl_r[24])))
		else $error("sync drive enable wrong");
	a_tx_quiet: assert property (!ctl_r[25] && !$past(ctl_r[25]) |-> $stable(DA_OUT))
		else $error("A output moved while receiving");
	c_held_read: cover property ($fell(REG_HOLD) && REG_RVALID);
	c_overflow: cover property (crd_r && REG_RVALID && REG_RDATA[29]);
	c_tx_stall: cover property (REG_HOLD && ctl_r[25]);
endmodule // spsb_top_asserts
bind spsb_top spsb_top_asserts u_chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
	.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
	.REG_RVALID(REG_RVALID), .REG_HOLD(REG_HOLD), .FS_OE(FS_OE), .DA_OE(DA_OE), .DA_OUT(DA_OUT));

//--- spsb_top_bench.sv
// Bench: receive queue, overflow, stalls and transmit order of the buffer block
`timescale 1ns/100ps
module spsb_top_bench;
	reg sys_clk;
	reg rst_n;
	reg [4:0] addr;
	reg [31:0] wdata;
	reg wr_s;
	reg rd_s;
	wire [31:0] rdata;
	wire rvalid;
	wire hold;
	wire sclk;
	wire fs;
	wire da_i;
	wire db_i;
	wire da_o;
	wire db_o;
	wire fs_o;
	wire fs_oe;
	integer n_mismatch;
	integer tests_run;
	integer k;
	reg [31:0] got;
	reg [31:0] row_a [0:2];
	reg [31:0] row_b [0:2];
	reg [5:0] row_st [0:2];
	spsb_top uut (.SYS_CLK(sys_clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr_s),
		.REG_RD(rd_s), .REG_RDATA(rdata), .REG_RVALID(rvalid), .REG_HOLD(hold), .SCLK_IN(sclk), .FS_IN(fs),
		.FS_OUT(fs_o), .FS_OE(fs_oe), .DA_IN(da_i), .DB_IN(db_i), .DA_OUT(da_o), .DB_OUT(db_o), .DA_OE(),
		.DB_OE());
	spsb_codec cdc (.sclk(sclk), .fs(fs), .da(da_i), .db(db_i), .qa(da_o), .qb(db_o));
	// 125 MHz system clock
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	task results;
		begin
			if (n_mismatch == 0 && tests_run > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			tests_run = tests_run + 1;
			if (seen !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
			end
		end
	endtask
	task wr(input [4:0] a, input [31:0] d);
		begin
			@(posedge sys_clk);
			addr <= a;
			wdata <= d;
			wr_s <= 1'b1;
			@(posedge sys_clk);
			wr_s <= 1'b0;
		end
	endtask
	// Read with a bounded wait, since an empty buffer stalls the answer
	task rd(input [4:0] a);
		integer i;
		begin
			@(posedge sys_clk);
			addr <= a;
			rd_s <= 1'b1;
			@(posedge sys_clk);
			rd_s <= 1'b0;
			#1;
			for (i = 0; i < 400 && rvalid !== 1'b1; i = i + 1) begin
				@(posedge sys_clk);
				#1;
			end
			if (i == 400) begin
				n_mismatch = n_mismatch + 1;
				$display("unexpected at %0t: no read data", $time);
				results;
			end
			got = rdata;
		end
	endtask
	task chs(input [5:0] e);
		begin
			rd(5'h00);
			chk({26'h0, got[31:26]}, {26'h0, e});
		end
	endtask
	initial begin
		n_mismatch = 0;
		tests_run = 0;
		rst_n = 1'b0;
		addr = 5'h00;
		wdata = 32'h0000_0000;
		wr_s = 1'b0;
		rd_s = 1'b0;
		row_a[0] = 32'h0000_00A5;
		row_a[1] = 32'h0000_003C;
		row_a[2] = 32'h0000_0096;
		row_b[0] = 32'h0000_005A;
		row_b[1] = 32'h0000_00C3;
		row_b[2] = 32'h0000_0069;
		row_st[0] = 6'h24;
		row_st[1] = 6'h36;
		row_st[2] = 6'h3F;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(5'h00);
		chk(got, 32'h0000_0000);
		rd(5'h04);
		chk(got, 32'h0000_0000);
		// Receive, both channels, 8-bit words; queue fills then overflows
		wr(5'h00, 32'h0100_0071);
		for (k = 0; k < 3; k = k + 1) begin
			cdc.frame(row_a[k], row_b[k], 8);
			chs(row_st[k]);
		end
		rd(5'h10);
		chk(got, row_a[0]);
		rd(5'h10);
		chk(got, row_a[2]);
		rd(5'h14);
		chk(got, row_b[0]);
		chs(6'h0D);
		wr(5'h00, 32'h0000_0070);
		chs(6'h04);
		rd(5'h14);
		chk(got, row_b[2]);
		chs(6'h00);
		// Read of an empty buffer waits for the serial side
		wr(5'h00, 32'h0100_0071);
		fork
			rd(5'h10);
			cdc.frame(32'h0000_003B, 32'h0000_00B3, 8);
		join
		chk(got, 32'h0000_003B);
		// Transmit side is dead while receiving; only reset frees the core
		wr(5'h08, 32'h0000_0011);
		wr(5'h08, 32'h0000_0012);
		wr(5'h08, 32'h0000_0013);
		cdc.frame(32'h0000_0000, 32'h0000_0000, 8);
		chk({31'h0, hold}, 32'h0000_0001);
		@(posedge sys_clk) rst_n <= 1'b0;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk) #1 chk({31'h0, hold}, 32'h0000_0000);
		// Disabled port: software may load a receive buffer and read it back
		wr(5'h10, 32'h0000_0055);
		chs(6'h20);
		rd(5'h10);
		chk(got, 32'h0000_0055);
		// Transmit with sync required: two words queue, third stalls
		wr(5'h00, 32'h0300_2071);
		wr(5'h08, 32'h0000_00C1);
		wr(5'h0C, 32'h0000_0081);
		wr(5'h08, 32'h0000_00C2);
		wr(5'h0C, 32'h0000_0082);
		chs(6'h36);
		fork
			wr(5'h08, 32'h0000_00C3);
			cdc.frame(32'h0000_0000, 32'h0000_0000, 8);
		join
		chk({31'h0, hold}, 32'h0000_0000);
		chk(cdc.ra, 32'h0000_00C1);
		chk(cdc.rb, 32'h0000_0081);
		cdc.frame(32'h0000_0000, 32'h0000_0000, 8);
		chk(cdc.ra, 32'h0000_00C2);
		chk(cdc.rb, 32'h0000_0082);
		cdc.frame(32'h0000_0000, 32'h0000_0000, 8);
		chk(cdc.ra, 32'h0000_00C3);
		chs(6'h01);
		// Internal sync waits for data unless the data-independent option is set
		wr(5'h00, 32'h0200_6071);
		@(posedge sys_clk) #1 chk({31'h0, fs_oe}, 32'h0000_0001);
		fork
			cdc.frame(32'h0000_0000, 32'h0000_0000, 8);
			begin
				got = 32'h0000_0000;
				repeat (90) @(posedge sys_clk) if (fs_o === 1'b1) got = 32'h0000_0001;
				chk(got, 32'h0000_0000);
			end
		join
		chs(6'h00);
		wr(5'h00, 32'h0200_E071);
		fork
			cdc.frame(32'h0000_0000, 32'h0000_0000, 8);
			begin
				for (k = 0; k < 90 && fs_o !== 1'b1; k = k + 1)
					@(posedge sys_clk);
				chk({31'h0, fs_o}, 32'h0000_0001);
			end
		join
		chs(6'h08);
		// Transmit direction: the receive side never fills, so a read stays held
		@(posedge sys_clk) begin
			addr <= 5'h10;
			rd_s <= 1'b1;
		end
		@(posedge sys_clk) rd_s <= 1'b0;
		cdc.frame(32'h0000_00FF, 32'h0000_00FF, 8);
		chk({31'h0, hold}, 32'h0000_0001);
		results;
	end
endmodule // spsb_top_bench
